// ---- bench/tb.sv ----
/*
 * Self-checking bench for the channel 0 I/O control block.
 * Assumes the design and pin model are compiled first.
 */
`include "tioc_params.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [5:0] HI = `TIOC_OFS_IOC_HIGH_CH0;
  localparam logic [5:0] LO0 = `TIOC_OFS_IOC_LOW_CH0;
  localparam logic [5:0] LO3 = `TIOC_OFS_IOC_LOW_CH3;
  localparam logic [5:0] CTL = `TIOC_OFS_CONTROL;
  localparam logic [5:0] GB = `TIOC_OFS_GREG_B;
  localparam logic [5:0] GD = `TIOC_OFS_GREG_D;
  localparam logic [5:0] ST = `TIOC_OFS_STATUS;
  localparam logic [5:0] MSK = `TIOC_OFS_MASK;
  logic        ref_clk = 0;
  logic        reset_n = 0;
  logic [5:0]  avs_address = 0;
  logic        avs_read = 0;
  logic        avs_write = 0;
  logic [31:0] avs_writedata = 0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [15:0] counter_value = 0;
  logic        counter_ch1_event = 0;
  logic        ext_b = 0;
  logic        ext_d = 0;
  logic        pin_b, pin_d, b_out, b_oe_n, d_out, d_oe_n, irq;
  logic [3:0]  c3, d3;
  logic [31:0] rd;
  logic [15:0] r;
  logic [2:0]  psc;
  logic        hit;
  int          error_cnt = 0;
  int          samples_checked = 0;
  int          seed = 4;

  always #20 ref_clk = ~ref_clk;

  tioc_ctrl #(.CNT_W(16)) tioc_ctrl_i (.ref_clk(ref_clk), .reset_n(reset_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .counter_value(counter_value),
    .counter_ch1_event(counter_ch1_event), .pin_b_ch0_in(pin_b), .pin_b_ch0_out(b_out),
    .pin_b_ch0_oe_n(b_oe_n), .pin_d_ch0_in(pin_d), .pin_d_ch0_out(d_out),
    .pin_d_ch0_oe_n(d_oe_n), .reg_c_code_ch3(c3), .reg_d_code_ch3(d3), .irq(irq));

  tioc_pin_model tioc_pin_model_i (.ext_b(ext_b), .ext_d(ext_d), .out_b(b_out),
    .oe_n_b(b_oe_n), .out_d(d_out), .oe_n_d(d_oe_n), .pin_b(pin_b), .pin_d(pin_d));

  // ******************************
  // Tasks
  // ******************************
  task automatic report_and_stop();
    $display("Checks %0d, errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 0;
    avs_write <= 0;
    chk("wait_cycles", 2, n);
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1, a, d);
  endtask

  task automatic rdchk(input string n, input logic [5:0] a, input logic [31:0] e);
    bus(0, a, 0);
    chk(n, e, rd);
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
  endtask

  function automatic logic exp_pin(input logic [3:0] c);
    case (c[1:0])
      2'b01: return 1'b0;
      2'b10: return 1'b1;
      default: return !c[2];
    endcase
  endfunction

  // ******************************
  // Sequence
  // ******************************
  initial begin
    #(40 * 20000);
    error_cnt++;
    report_and_stop();
  end

  initial begin
    tick(12);
    reset_n <= 1;
    tick(3);
    rdchk("io_high", HI, 0);
    rdchk("io_low0", LO0, 0);
    rdchk("io_low3", LO3, 0);
    rdchk("greg_b", GB, 32'h0000_ffff);
    wr(6'h20, $random(seed));
    rdchk("unmapped", 6'h20, 0);
    r = $random(seed);
    wr(LO3, r[7:0]);
    rdchk("io_low3", LO3, r[7:0]);
    chk("code_c3", r[3:0], c3);
    chk("code_d3", r[7:4], d3);
    wr(LO0, r[15:8]);
    rdchk("io_low0", LO0, r[15:8]);
    r = $random(seed) | 16'h0001;
    wr(GB, r);
    for (int i = 0; i < 8; i++) begin
      wr(CTL, 0);
      wr(HI, {i[3:0], 4'h0});
      tick(2);
      chk("oe_n_b", i % 4 == 0, b_oe_n);
      chk("pin_b_init", i[2], b_out);
      wr(CTL, 1);
      counter_value <= r;
      tick(1);
      counter_value <= ~r;
      tick(3);
      if (i % 4 != 0) chk("pin_b_match", exp_pin(i[3:0]), b_out);
      rdchk("status", ST, 1);
      wr(ST, 1);
      rdchk("status", ST, 0);
    end
    wr(HI, 8'h80);
    wr(MSK, 2);
    for (int i = 8; i < 12; i++) begin
      for (int e = 0; e < 2; e++) begin
        wr(LO0, {i[3:0], 4'h0});
        wr(GD, 0);
        wr(ST, 3);
        r = $random(seed);
        counter_value <= r;
        ext_d <= (e == 0);
        tick(3);
        hit = e ? i != 8 : i != 9;
        chk("irq", hit, irq);
        rdchk("greg_d", GD, hit ? r : 0);
        rdchk("status", ST, {hit, 1'b0});
      end
    end
    wr(MSK, 0);
    tick(1);
    chk("irq_masked", 0, irq);
    for (int i = 12; i < 16; i++) begin
      psc = (i == 13) ? 3'h0 : 3'(i - 11);
      wr(CTL, {psc, 2'b01});
      wr(HI, {i[3:0], 4'h0});
      wr(ST, 3);
      r = $random(seed);
      counter_value <= r;
      counter_ch1_event <= 1;
      tick(1);
      counter_ch1_event <= 0;
      tick(3);
      hit = psc != 0;
      rdchk("status", ST, hit);
      if (hit) rdchk("greg_b", GB, r);
    end
    wr(CTL, 0);
    wr(LO0, 8'h50);
    tick(2);
    chk("pin_d_init", 1, d_out);
    chk("oe_n_d_on", 0, d_oe_n);
    wr(CTL, 2);
    wr(LO0, 8'h10);
    tick(2);
    chk("oe_n_d", 1, d_oe_n);
    wr(CTL, 3);
    wr(LO0, 8'h80);
    wr(ST, 3);
    ext_d <= 1;
    tick(3);
    rdchk("status", ST, 0);
    report_and_stop();
  end
endmodule

// ---- bench/tioc_pin_model.sv ----
/*
 * Partner model: external drivers on the channel 0 capture/compare pins.
 * Assumes the bench sets the external levels just after a rising edge.
 */
module tioc_pin_model (
  input  wire logic ext_b,
  input  wire logic ext_d,
  input  wire logic out_b,
  input  wire logic oe_n_b,
  input  wire logic out_d,
  input  wire logic oe_n_d,
  output logic      pin_b,
  output logic      pin_d
);
  timeunit 1ns;
  timeprecision 1ns;
  // Module drive wins; otherwise the external source sets the level
  assign pin_b = oe_n_b ? ext_b : out_b;
  assign pin_d = oe_n_d ? ext_d : out_d;
endmodule

// ---- inc/tioc_params.svh ----
/*
 * Register offsets, field positions and reset values of the channel 0 I/O control block.
 * Assumes inclusion by bare name from the package and the design file.
 */
`ifndef TIOC_PARAMS_SVH
`define TIOC_PARAMS_SVH
`define TIOC_OFS_IOC_HIGH_CH0 6'h00
`define TIOC_OFS_IOC_LOW_CH0  6'h04
`define TIOC_OFS_IOC_LOW_CH3  6'h08
`define TIOC_OFS_CONTROL      6'h0c
`define TIOC_OFS_GREG_B       6'h10
`define TIOC_OFS_GREG_D       6'h14
`define TIOC_OFS_STATUS       6'h18
`define TIOC_OFS_MASK         6'h1c
`define TIOC_IOC_RESET        8'h00
`define TIOC_CTL_RESET        8'h00
`define TIOC_GREG_RESET       16'hffff
`define TIOC_CTL_START_BIT    0
`define TIOC_CTL_BUFFER_BIT   1
`define TIOC_CTL_PSC_LSB      2
`define TIOC_CODE_B_LSB       4
`define TIOC_CODE_D_LSB       4
`define TIOC_CODE_C_LSB       0
`define TIOC_PSC_UNDIVIDED    3'h0
`define TIOC_UNMAPPED_DATA    32'h0000_0000
`endif

// ---- inc/tioc_pkg.sv ----
/*
 * Types shared by the channel 0 I/O control block.
 * Assumes tioc_params.svh is on the include path.
 */
`include "tioc_params.svh"
package tioc_pkg;
  typedef logic [3:0] tioc_code_t;
  typedef enum logic [1:0] {
    TIOC_ACT_NONE   = 2'b00,
    TIOC_ACT_LOW    = 2'b01,
    TIOC_ACT_HIGH   = 2'b10,
    TIOC_ACT_TOGGLE = 2'b11
  } tioc_action_e;
  typedef enum logic [2:0] {
    TIOC_SRC_COMPARE = 3'b000,
    TIOC_SRC_RISE    = 3'b001,
    TIOC_SRC_FALL    = 3'b010,
    TIOC_SRC_BOTH    = 3'b011,
    TIOC_SRC_CH1     = 3'b100
  } tioc_src_e;
endpackage

// ---- logic/tioc_ctrl.sv ----
/*
 * Channel 0 I/O control: decodes the 4-bit codes of general registers B and D,
 * runs their compare outputs and capture triggers, and holds the low I/O control
 * register of channel 3 for that channel's logic.
 * Assumes an Avalon-MM master, a counter value and a channel 1 count event
 * supplied by the surrounding timer, and pins synchronous to ref_clk.
 */
// Chosen here: the register offsets and the Avalon-MM slave port.
`include "tioc_params.svh"

// Summary of operation
// [RULE_01] Low register: D upper nibble, C lower
// [RULE_02] High register upper nibble configures register B
// [RULE_03] Codes 0000, 0100: compare, pin disabled
// [RULE_04] Codes 0001-0011: compare, initial level low
// [RULE_05] Codes 0101-0111: compare, initial level high
// [RULE_06] Low two bits: low, high, toggle
// [RULE_07] Top bit set selects input capture
// [RULE_08] Code 1000 captures on rising pin edge
// [RULE_09] Code 1001 captures on falling pin edge
// [RULE_10] Codes 101x capture on both edges
// [RULE_11] Codes 11xx capture on channel 1 counts
// [RULE_12] Undivided channel 1 clock gives no capture
// [RULE_13] Initial level applies only while counter stopped
// [RULE_14] Buffered register D ignores its code
// [RULE_15] Software readies pin direction before capture
// [RULE_16] Capture copies counter and raises flag
module tioc_ctrl
  import tioc_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  input  wire logic [5:0]       avs_address,
  input  wire logic             avs_read,
  input  wire logic             avs_write,
  input  wire logic [31:0]      avs_writedata,
  output logic      [31:0]      avs_readdata,
  output logic                  avs_waitrequest,
  input  wire logic [CNT_W-1:0] counter_value,
  input  wire logic             counter_ch1_event,
  input  wire logic             pin_b_ch0_in,
  output logic                  pin_b_ch0_out,
  output logic                  pin_b_ch0_oe_n,
  input  wire logic             pin_d_ch0_in,
  output logic                  pin_d_ch0_out,
  output logic                  pin_d_ch0_oe_n,
  output logic      [3:0]       reg_c_code_ch3,
  output logic      [3:0]       reg_d_code_ch3,
  output logic                  irq
);

  // ****************************************************************
  // Reset release and code decode
  // ****************************************************************
  logic rst_meta_q;
  logic rst_n_q;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  function automatic tioc_src_e decode_src(input tioc_code_t code);
    if (!code[3]) begin
      decode_src = TIOC_SRC_COMPARE;
    end else if (code[2]) begin
      decode_src = TIOC_SRC_CH1;
    end else if (code[1]) begin
      decode_src = TIOC_SRC_BOTH;
    end else if (code[0]) begin
      decode_src = TIOC_SRC_FALL;
    end else begin
      decode_src = TIOC_SRC_RISE;
    end
  endfunction

  // ****************************************************************
  // Register bus
  // ****************************************************************
  logic [7:0]       ioc_high_ch0_q;
  logic [7:0]       ioc_low_ch0_q;
  logic [7:0]       ioc_low_ch3_q;
  logic [7:0]       control_q;
  logic [1:0]       status_q;
  logic [1:0]       mask_q;
  logic [CNT_W-1:0] greg_q [2];
  logic             ack_q;
  logic             wr_go;
  logic [1:0]       flag_set;
  logic [31:0]      rdata_d;

  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
  assign wr_go           = avs_write & ack_q;

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (avs_read | avs_write) & ~ack_q;
    end
  end

  always_comb begin
    rdata_d = `TIOC_UNMAPPED_DATA;
    case (avs_address)
      `TIOC_OFS_IOC_HIGH_CH0: rdata_d = {24'h000000, ioc_high_ch0_q};
      `TIOC_OFS_IOC_LOW_CH0:  rdata_d = {24'h000000, ioc_low_ch0_q};
      `TIOC_OFS_IOC_LOW_CH3:  rdata_d = {24'h000000, ioc_low_ch3_q};
      `TIOC_OFS_CONTROL:      rdata_d = {24'h000000, control_q};
      `TIOC_OFS_GREG_B:       rdata_d = 32'(greg_q[0]);
      `TIOC_OFS_GREG_D:       rdata_d = 32'(greg_q[1]);
      `TIOC_OFS_STATUS:       rdata_d = {30'h0, status_q};
      `TIOC_OFS_MASK:         rdata_d = {30'h0, mask_q};
      default:                rdata_d = `TIOC_UNMAPPED_DATA;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read & ~ack_q) begin
      avs_readdata <= rdata_d;
    end
  end

  // Configuration registers, all bits read/write
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ioc_high_ch0_q <= `TIOC_IOC_RESET;
      ioc_low_ch0_q  <= `TIOC_IOC_RESET; // RULE_01
      ioc_low_ch3_q  <= `TIOC_IOC_RESET; // RULE_01
      control_q      <= `TIOC_CTL_RESET;
      mask_q         <= 2'h0;
    end else if (wr_go) begin
      case (avs_address)
        `TIOC_OFS_IOC_HIGH_CH0: ioc_high_ch0_q <= avs_writedata[7:0];
        `TIOC_OFS_IOC_LOW_CH0:  ioc_low_ch0_q  <= avs_writedata[7:0]; // RULE_01
        `TIOC_OFS_IOC_LOW_CH3:  ioc_low_ch3_q  <= avs_writedata[7:0]; // RULE_01
        `TIOC_OFS_CONTROL:      control_q      <= avs_writedata[7:0];
        `TIOC_OFS_MASK:         mask_q         <= avs_writedata[1:0];
        default:                mask_q         <= mask_q;
      endcase
    end
  end

  assign reg_d_code_ch3 = ioc_low_ch3_q[`TIOC_CODE_D_LSB +: 4]; // RULE_01
  assign reg_c_code_ch3 = ioc_low_ch3_q[`TIOC_CODE_C_LSB +: 4]; // RULE_01

  // ****************************************************************
  // Channel logic for general registers B and D
  // ****************************************************************
  logic             start;
  logic             buffer_d;
  logic [2:0]       psc_ch1;
  tioc_code_t       code   [2];
  logic             pin_in [2];
  logic             pin_out_q [2];
  logic             pin_oe_n [2];
  logic             pin_prev_q [2];
  logic             active [2];
  logic             capt_ev [2];
  logic             match_ev [2];

  assign start    = control_q[`TIOC_CTL_START_BIT];
  assign buffer_d = control_q[`TIOC_CTL_BUFFER_BIT];
  assign psc_ch1  = control_q[`TIOC_CTL_PSC_LSB +: 3];
  assign code[0]  = ioc_high_ch0_q[`TIOC_CODE_B_LSB +: 4]; // RULE_02
  assign code[1]  = ioc_low_ch0_q[`TIOC_CODE_D_LSB +: 4];  // RULE_01
  assign pin_in[0] = pin_b_ch0_in;
  assign pin_in[1] = pin_d_ch0_in;
  assign active[0] = 1'b1;
  assign active[1] = ~buffer_d; // RULE_14

  generate
    for (genvar i = 0; i < 2; i++) begin : g_chan
      tioc_src_e src;
      logic      rise;
      logic      fall;

      assign src  = decode_src(code[i]); // RULE_07
      assign rise = pin_in[i] & ~pin_prev_q[i];
      assign fall = ~pin_in[i] & pin_prev_q[i];

      always_comb begin
        capt_ev[i] = 1'b0;
        case (src)
          TIOC_SRC_RISE: capt_ev[i] = rise;        // RULE_08
          TIOC_SRC_FALL: capt_ev[i] = fall;        // RULE_09
          TIOC_SRC_BOTH: capt_ev[i] = rise | fall; // RULE_10
          TIOC_SRC_CH1:  capt_ev[i] = counter_ch1_event &
                                      (psc_ch1 != `TIOC_PSC_UNDIVIDED); // RULE_11 RULE_12
          default:       capt_ev[i] = 1'b0;
        endcase
        capt_ev[i] = capt_ev[i] & active[i]; // RULE_14
      end

      assign match_ev[i] = active[i] & (src == TIOC_SRC_COMPARE) & start &
                           (counter_value == greg_q[i]);
      // Pin driven only for compare codes with a nonzero action
      assign pin_oe_n[i] = ~(active[i] & ~code[i][3] & (code[i][1:0] != 2'b00)); // RULE_03

      always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
          pin_prev_q[i] <= 1'b0;
        end else begin
          pin_prev_q[i] <= pin_in[i];
        end
      end

      always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
          pin_out_q[i] <= 1'b0;
        end else if (!start) begin
          pin_out_q[i] <= code[i][2]; // RULE_04 RULE_05 RULE_13
        end else if (match_ev[i]) begin
          case (tioc_action_e'(code[i][1:0]))
            TIOC_ACT_LOW:    pin_out_q[i] <= 1'b0;          // RULE_06
            TIOC_ACT_HIGH:   pin_out_q[i] <= 1'b1;          // RULE_06
            TIOC_ACT_TOGGLE: pin_out_q[i] <= ~pin_out_q[i]; // RULE_06
            default:         pin_out_q[i] <= pin_out_q[i];
          endcase
        end
      end

      always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
          greg_q[i] <= `TIOC_GREG_RESET;
        end else if (capt_ev[i]) begin
          greg_q[i] <= counter_value; // RULE_16
        end else if (wr_go && avs_address == (i == 0 ? `TIOC_OFS_GREG_B : `TIOC_OFS_GREG_D)) begin
          greg_q[i] <= avs_writedata[CNT_W-1:0];
        end
      end

      assign flag_set[i] = capt_ev[i] | match_ev[i]; // RULE_16
    end
  endgenerate

  assign pin_b_ch0_out  = pin_out_q[0];
  assign pin_d_ch0_out  = pin_out_q[1];
  assign pin_b_ch0_oe_n = pin_oe_n[0];
  assign pin_d_ch0_oe_n = pin_oe_n[1];

  // ****************************************************************
  // Flags and interrupt
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      status_q <= 2'h0;
    end else if (wr_go && avs_address == `TIOC_OFS_STATUS) begin
      status_q <= (status_q & ~avs_writedata[1:0]) | flag_set; // RULE_16
    end else begin
      status_q <= status_q | flag_set; // RULE_16
    end
  end

  assign irq = |(status_q & mask_q);

  // ****************************************************************
  // Checks
  // ****************************************************************
  capt_copies_a: assert property (@(posedge ref_clk) disable iff (!rst_n_q) // RULE_16
    capt_ev[0] |=> (greg_q[0] == $past(counter_value)) && status_q[0])
    else $error("Capture on B did not copy counter or set flag");

  rise_capture_a: assert property (@(posedge ref_clk) disable iff (!rst_n_q) // RULE_08
    (code[1] == 4'h8) && !buffer_d && pin_d_ch0_in && !$past(pin_d_ch0_in) |-> capt_ev[1])
    else $error("Rising edge on D not captured");

  fall_capture_a: assert property (@(posedge ref_clk) disable iff (!rst_n_q) // RULE_09
    (code[1] == 4'h9) && pin_d_ch0_in && !$past(pin_d_ch0_in) |-> !capt_ev[1])
    else $error("Rising edge captured in falling mode");

  both_edges_a: assert property (@(posedge ref_clk) disable iff (!rst_n_q) // RULE_10
    (code[1][3:1] == 3'b101) && !buffer_d && (pin_d_ch0_in != $past(pin_d_ch0_in))
    |-> capt_ev[1])
    else $error("Edge on D not captured in both-edge mode");

  ch1_undivided_a: assert property (@(posedge ref_clk) disable iff (!rst_n_q) // RULE_12
    (code[0][3:2] == 2'b11) && (psc_ch1 == 3'h0) |-> !capt_ev[0])
    else $error("Channel 1 capture with undivided clock");

  buffer_d_quiet_a: assert property (@(posedge ref_clk) disable iff (!rst_n_q) // RULE_14
    buffer_d |-> !flag_set[1] && pin_d_ch0_oe_n)
    else $error("Buffered D still active");

  initial_level_a: assert property (@(posedge ref_clk) disable iff (!rst_n_q) // RULE_13
    !start && !code[0][3] ##1 !start && $stable(code[0]) |-> pin_b_ch0_out == code[0][2])
    else $error("Initial level not applied while stopped");

  disabled_pin_a: assert property (@(posedge ref_clk) disable iff (!rst_n_q) // RULE_03
    (code[0] == 4'h0 || code[0] == 4'h4) |-> pin_b_ch0_oe_n)
    else $error("Pin driven with output disabled code");

  toggle_match_a: assert property (@(posedge ref_clk) disable iff (!rst_n_q) // RULE_06
    start && match_ev[0] && (code[0][1:0] == 2'b11) ##1 start
    |-> pin_b_ch0_out != $past(pin_b_ch0_out))
    else $error("Toggle at compare match missing");

  compare_only_a: assert property (@(posedge ref_clk) disable iff (!rst_n_q) // RULE_07
    code[1][3] |-> !match_ev[1] && pin_d_ch0_oe_n)
    else $error("Capture code acting as compare");

endmodule
